// file: cdrsw_pkg.sv
package cdrsw_pkg;

    // clock and time base
    localparam int CDRSW_CLK_HZ = 20_000_000;
    localparam int CDRSW_HZ_PER_MHZ = 1_000_000;
    localparam int CDRSW_US_CYCLES = CDRSW_CLK_HZ / CDRSW_HZ_PER_MHZ;
    localparam logic [4:0] CDRSW_DIV_LAST = 5'(CDRSW_US_CYCLES - 1);
    localparam int CDRSW_LEAD_UNIT_US = 5;
    localparam int CDRSW_LAG_UNIT_US = 5;
    localparam int CDRSW_ON_UNIT_US = 8;
    localparam logic [10:0] CDRSW_LEAD_MUL = 11'(CDRSW_LEAD_UNIT_US);
    localparam logic [10:0] CDRSW_LAG_MUL = 11'(CDRSW_LAG_UNIT_US);
    localparam logic [10:0] CDRSW_ON_MUL = 11'(CDRSW_ON_UNIT_US);

    // register indices, byte address is four times the index
    localparam logic [7:0] CDRSW_IDX_STORED_REF = 8'h34;
    localparam logic [7:0] CDRSW_IDX_ON_TIME = 8'h36;
    localparam logic [7:0] CDRSW_IDX_THRESHOLD = 8'h37;
    localparam logic [7:0] CDRSW_IDX_CFG = 8'h38;
    localparam logic [7:0] CDRSW_IDX_LEAD = 8'h39;
    localparam logic [7:0] CDRSW_IDX_LAG = 8'h3a;
    localparam logic [7:0] CDRSW_IDX_TRIGGER = 8'h26;
    localparam logic [7:0] CDRSW_IDX_GAIN_REF = 8'h40;
    localparam logic [7:0] CDRSW_IDX_CTRL = 8'h41;
    localparam logic [7:0] CDRSW_IDX_IRQ_STATUS = 8'h42;
    localparam logic [7:0] CDRSW_IDX_IRQ_MASK = 8'h43;
    localparam logic [7:0] CDRSW_IDX_MEAS_REF = 8'h44;
    localparam int CDRSW_ADDR_W = 12;
    localparam int CDRSW_IDX_LSB = 2;

    // field positions
    localparam int CDRSW_CFG_LEAD_EN = 2;
    localparam int CDRSW_CFG_OUT2_DETECT = 3;
    localparam int CDRSW_CFG_OUT1_WAKE = 4;
    localparam int CDRSW_REF_VAL_MSB = 9;
    localparam int CDRSW_CTRL_LOOP = 0;
    localparam int CDRSW_IRQ_DETECT = 0;
    localparam int CDRSW_IRQ_DONE = 1;
    localparam int CDRSW_IRQ_W = 2;
    localparam int CDRSW_TRIG_DETECTED = 0;
    localparam int CDRSW_TRIG_BUSY = 1;

    // reference source codes
    localparam logic [1:0] CDRSW_SRC_STORED = 2'h0;
    localparam logic [1:0] CDRSW_SRC_MEASURE = 2'h1;
    localparam logic [1:0] CDRSW_SRC_GAIN_REF = 2'h2;
    localparam logic [1:0] CDRSW_SRC_RESERVED = 2'h3;

    typedef enum logic [2:0] {
        CDRSW_IDLE = 3'h0,
        CDRSW_STANDBY = 3'h1,
        CDRSW_LEAD = 3'h3,
        CDRSW_FIELD = 3'h2,
        CDRSW_LAG = 3'h6
    } cdrsw_fsm_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [CDRSW_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } cdrsw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cdrsw_apb_rsp_t;

    typedef struct packed {
        cdrsw_fsm_t fsm;
        logic [7:0] cfg;
        logic [7:0] lead;
        logic [7:0] lag;
        logic [7:0] on_time;
        logic [7:0] threshold;
        logic [13:0] stored_ref;
        logic [13:0] gain_ref;
        logic [13:0] meas_ref;
        logic ref_valid;
        logic loop_en;
        logic single;
        logic detected;
        logic [CDRSW_IRQ_W-1:0] irq_status;
        logic [CDRSW_IRQ_W-1:0] irq_mask;
        logic out_one;
        logic out_two;
        logic field;
        logic [4:0] tick_div;
        logic [10:0] us_cnt;
        logic [31:0] prdata;
        logic slverr;
    } cdrsw_state_t;

    localparam cdrsw_state_t CDRSW_RESET_STATE = '0;

endpackage

// file: cdrsw_core.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// How it works
// - Source 00 stored, 01 measured, 10 gain ref reg, 11 never detects.
// - Cfg bit 2 raises output one at wake-up, then the lead wait runs.
// - Cfg bit 3 raises output two on a detection; clear leaves it alone.
// - Cfg bit 4 drives output one high on wake-up and low after the lag.
// - With cfg bit 2 set, output one high to field on takes the lead byte times 5 us.
// - Field off to output one low takes the lag byte times 5 us.
// - A trigger register write in idle runs exactly one detection cycle.
// - A single check skips standby and starts at the lead phase.
// - The field stays on the on-time byte times 8 us before gain sampling.
// - A gain difference over the threshold raises detect status and irq.
// - Otherwise no detect interrupt is raised and the loop goes back to standby.
// - References hold a 10-bit value in bits 9:0 and a gear in bits 13:10.
module cdrsw_core
    import cdrsw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire cdrsw_pkg::cdrsw_apb_req_t apb_req,
    output cdrsw_pkg::cdrsw_apb_rsp_t apb_rsp,
    input wire logic standby_wake,
    input wire logic [9:0] gain_level,
    output logic sense_field_on,
    output logic general_output_one,
    output logic general_output_two,
    output logic card_detect_irq
);
    import cdrsw_pkg::*;

    cdrsw_state_t cur;
    cdrsw_state_t next_cur;

    function automatic logic is_mapped(input logic [7:0] idx);
        if (idx == CDRSW_IDX_STORED_REF) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_ON_TIME) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_THRESHOLD) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_CFG) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_LEAD) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_LAG) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_TRIGGER) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_GAIN_REF) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_CTRL) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_IRQ_STATUS) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_IRQ_MASK) begin
            is_mapped = 1'b1;
        end else if (idx == CDRSW_IDX_MEAS_REF) begin
            is_mapped = 1'b1;
        end else begin
            is_mapped = 1'b0;
        end
    endfunction

    function automatic logic [31:0] read_reg(input logic [7:0] idx,
                                             input cdrsw_state_t s);
        logic busy;
        busy = (s.fsm != CDRSW_IDLE);
        if (idx == CDRSW_IDX_STORED_REF) begin
            read_reg = {18'h0, s.stored_ref};
        end else if (idx == CDRSW_IDX_ON_TIME) begin
            read_reg = {24'h0, s.on_time};
        end else if (idx == CDRSW_IDX_THRESHOLD) begin
            read_reg = {24'h0, s.threshold};
        end else if (idx == CDRSW_IDX_CFG) begin
            read_reg = {24'h0, s.cfg};
        end else if (idx == CDRSW_IDX_LEAD) begin
            read_reg = {24'h0, s.lead};
        end else if (idx == CDRSW_IDX_LAG) begin
            read_reg = {24'h0, s.lag};
        end else if (idx == CDRSW_IDX_TRIGGER) begin
            read_reg = {30'h0, busy, s.detected};
        end else if (idx == CDRSW_IDX_GAIN_REF) begin
            read_reg = {18'h0, s.gain_ref};
        end else if (idx == CDRSW_IDX_CTRL) begin
            read_reg = {31'h0, s.loop_en};
        end else if (idx == CDRSW_IDX_IRQ_STATUS) begin
            read_reg = {30'h0, s.irq_status};
        end else if (idx == CDRSW_IDX_IRQ_MASK) begin
            read_reg = {30'h0, s.irq_mask};
        end else if (idx == CDRSW_IDX_MEAS_REF) begin
            read_reg = {17'h0, s.ref_valid, s.meas_ref};
        end else begin
            read_reg = 32'h0;
        end
    endfunction

    function automatic logic [9:0] abs_diff(input logic [9:0] a,
                                            input logic [9:0] b);
        if (a >= b) begin
            abs_diff = a - b;
        end else begin
            abs_diff = b - a;
        end
    endfunction

    logic [7:0] idx;
    logic setup;
    logic wr;
    logic tick;
    logic use_out1;
    logic use_lead;
    logic [1:0] src;
    logic [9:0] ref_val;
    logic [10:0] lead_target;
    logic [10:0] lag_target;
    logic [10:0] on_target;
    logic hit;
    logic capture;
    logic trig_wr;
    logic [CDRSW_IRQ_W-1:0] irq_set;
    logic [CDRSW_IRQ_W-1:0] irq_clr;

    always_comb begin
        next_cur = cur;
        idx = apb_req.paddr[CDRSW_IDX_LSB +: 8];
        setup = apb_req.psel & ~apb_req.penable;
        wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
        tick = (cur.tick_div == CDRSW_DIV_LAST);
        use_out1 = cur.cfg[CDRSW_CFG_LEAD_EN] | cur.cfg[CDRSW_CFG_OUT1_WAKE];
        use_lead = cur.cfg[CDRSW_CFG_LEAD_EN];
        src = cur.cfg[1:0];
        lead_target = use_lead ? 11'({3'h0, cur.lead} * CDRSW_LEAD_MUL)
                               : 11'h0;
        lag_target = use_out1 ? 11'({3'h0, cur.lag} * CDRSW_LAG_MUL)
                              : 11'h0;
        on_target = 11'({3'h0, cur.on_time} * CDRSW_ON_MUL);
        ref_val = cur.stored_ref[CDRSW_REF_VAL_MSB:0];
        hit = 1'b0;
        capture = 1'b0;
        trig_wr = wr & (idx == CDRSW_IDX_TRIGGER);
        irq_set = '0;
        irq_clr = '0;

        // microsecond time base
        if (tick) begin
            next_cur.tick_div = 5'h0;
        end else begin
            next_cur.tick_div = cur.tick_div + 5'h1;
        end
        if (tick) begin
            next_cur.us_cnt = cur.us_cnt + 11'h1;
        end

        // reference selection
        case (src)
            CDRSW_SRC_STORED: begin
                ref_val = cur.stored_ref[CDRSW_REF_VAL_MSB:0];
            end
            CDRSW_SRC_MEASURE: begin
                ref_val = cur.meas_ref[CDRSW_REF_VAL_MSB:0];
            end
            CDRSW_SRC_GAIN_REF: begin
                ref_val = cur.gain_ref[CDRSW_REF_VAL_MSB:0];
            end
            default: begin
                ref_val = cur.stored_ref[CDRSW_REF_VAL_MSB:0];
            end
        endcase

        // register reads and writes
        if (setup) begin
            next_cur.prdata = read_reg(idx, cur);
            next_cur.slverr = ~is_mapped(idx);
        end
        if (wr) begin
            if (idx == CDRSW_IDX_STORED_REF) begin
                next_cur.stored_ref = apb_req.pwdata[13:0];
            end else if (idx == CDRSW_IDX_ON_TIME) begin
                next_cur.on_time = apb_req.pwdata[7:0];
            end else if (idx == CDRSW_IDX_THRESHOLD) begin
                next_cur.threshold = apb_req.pwdata[7:0];
            end else if (idx == CDRSW_IDX_CFG) begin
                next_cur.cfg = apb_req.pwdata[7:0];
                next_cur.ref_valid = 1'b0;
            end else if (idx == CDRSW_IDX_LEAD) begin
                next_cur.lead = apb_req.pwdata[7:0];
            end else if (idx == CDRSW_IDX_LAG) begin
                next_cur.lag = apb_req.pwdata[7:0];
            end else if (idx == CDRSW_IDX_GAIN_REF) begin
                next_cur.gain_ref = apb_req.pwdata[13:0];
            end else if (idx == CDRSW_IDX_CTRL) begin
                next_cur.loop_en = apb_req.pwdata[CDRSW_CTRL_LOOP];
            end else if (idx == CDRSW_IDX_IRQ_STATUS) begin
                irq_clr = apb_req.pwdata[CDRSW_IRQ_W-1:0];
            end else if (idx == CDRSW_IDX_IRQ_MASK) begin
                next_cur.irq_mask = apb_req.pwdata[CDRSW_IRQ_W-1:0];
            end
        end

        case (cur.fsm)
            CDRSW_IDLE: begin
                if (trig_wr) begin
                    next_cur.single = 1'b1;
                    next_cur.detected = 1'b0;
                    if (use_out1) begin
                        next_cur.out_one = 1'b1;
                    end
                    next_cur.us_cnt = 11'h0;
                    next_cur.tick_div = 5'h0;
                    next_cur.fsm = CDRSW_LEAD;
                end else if (cur.loop_en) begin
                    next_cur.detected = 1'b0;
                    next_cur.fsm = CDRSW_STANDBY;
                end
            end
            CDRSW_STANDBY: begin
                if (!cur.loop_en) begin
                    next_cur.fsm = CDRSW_IDLE;
                end else if (standby_wake) begin
                    if (use_out1) begin
                        next_cur.out_one = 1'b1;
                    end
                    next_cur.us_cnt = 11'h0;
                    next_cur.tick_div = 5'h0;
                    next_cur.fsm = CDRSW_LEAD;
                end
            end
            CDRSW_LEAD: begin
                if (cur.us_cnt >= lead_target) begin
                    next_cur.field = 1'b1;
                    next_cur.us_cnt = 11'h0;
                    next_cur.tick_div = 5'h0;
                    next_cur.fsm = CDRSW_FIELD;
                end
            end
            CDRSW_FIELD: begin
                if (cur.us_cnt >= on_target) begin
                    if (src == CDRSW_SRC_MEASURE && !cur.ref_valid) begin
                        capture = 1'b1;
                    end else if (src != CDRSW_SRC_RESERVED) begin
                        hit = abs_diff(ref_val, gain_level)
                              > {2'h0, cur.threshold};
                    end
                    if (capture) begin
                        next_cur.meas_ref = {4'h0, gain_level};
                        next_cur.ref_valid = 1'b1;
                    end
                    next_cur.detected = hit;
                    if (hit) begin
                        irq_set[CDRSW_IRQ_DETECT] = 1'b1;
                        next_cur.loop_en = 1'b0;
                        if (cur.cfg[CDRSW_CFG_OUT2_DETECT]) begin
                            next_cur.out_two = 1'b1;
                        end
                    end
                    next_cur.field = 1'b0;
                    next_cur.us_cnt = 11'h0;
                    next_cur.tick_div = 5'h0;
                    next_cur.fsm = CDRSW_LAG;
                end
            end
            CDRSW_LAG: begin
                if (cur.us_cnt >= lag_target) begin
                    if (use_out1) begin
                        next_cur.out_one = 1'b0;
                    end
                    if (cur.single) begin
                        next_cur.single = 1'b0;
                        irq_set[CDRSW_IRQ_DONE] = 1'b1;
                        next_cur.fsm = CDRSW_IDLE;
                    end else if (cur.detected || !next_cur.loop_en) begin
                        next_cur.fsm = CDRSW_IDLE;
                    end else begin
                        next_cur.fsm = CDRSW_STANDBY;
                    end
                end
            end
            default: begin
                next_cur.fsm = CDRSW_IDLE;
            end
        endcase

        // sticky status, a set in the clearing cycle wins
        for (int i = 0; i < CDRSW_IRQ_W; i++) begin
            next_cur.irq_status[i] = irq_set[i]
                                     | (cur.irq_status[i] & ~irq_clr[i]);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= CDRSW_RESET_STATE;
        end else begin
            cur <= next_cur;
        end
    end

    always_comb begin
        apb_rsp.prdata = cur.prdata;
        apb_rsp.pready = apb_req.psel & apb_req.penable;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable & cur.slverr;
    end

    assign sense_field_on = cur.field;
    assign general_output_one = cur.out_one;
    assign general_output_two = cur.out_two;
    assign card_detect_irq = |(cur.irq_status & cur.irq_mask);

endmodule

// file: cdrsw_props.sv
`timescale 1ns/1ps
module cdrsw_props
    import cdrsw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire cdrsw_pkg::cdrsw_apb_req_t apb_req,
    input wire cdrsw_pkg::cdrsw_apb_rsp_t apb_rsp,
    input wire logic standby_wake,
    input wire logic [9:0] gain_level,
    input wire logic sense_field_on,
    input wire logic general_output_one,
    input wire logic general_output_two,
    input wire logic card_detect_irq
);
    import cdrsw_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [15:0] on_cnt;
    logic [15:0] off_cnt;
    // lengths of the current field-on and field-off stretches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            on_cnt <= 16'h0;
            off_cnt <= 16'h0;
        end else begin
            on_cnt <= sense_field_on ? on_cnt + 16'h1 : 16'h0;
            off_cnt <= sense_field_on ? 16'h0 : off_cnt + 16'h1;
        end
    end
    ready_in_access_a: assert property (apb_rsp.pready ==
        (apb_req.psel && apb_req.penable)) else $error("pready wrong");
    err_in_access_a: assert property (apb_rsp.pslverr |->
        apb_req.psel && apb_req.penable) else $error("pslverr stray");
    field_span_a: assert property ($fell(sense_field_on) |->
        on_cnt % 16'h00a0 == 16'h1) else $error("field time wrong");
    lag_span_a: assert property ($fell(general_output_one) |->
        off_cnt % 16'h0064 == 16'h1) else $error("lag time wrong");
    out1_first_a: assert property ($rose(general_output_one) |->
        !sense_field_on) else $error("output one after field");
    out2_sticky_a: assert property (!$fell(general_output_two))
        else $error("output two dropped");
    out2_on_hit_a: assert property ($rose(general_output_two) |->
        !sense_field_on && ($past(sense_field_on) ||
        $past(sense_field_on, 2))) else $error("output two untimely");
    irq_after_a: assert property ($rose(card_detect_irq) |->
        !sense_field_on) else $error("irq during field");
endmodule

bind cdrsw_core cdrsw_props u_props (
    .core_clk(core_clk),
    .rst(rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .standby_wake(standby_wake),
    .gain_level(gain_level),
    .sense_field_on(sense_field_on),
    .general_output_one(general_output_one),
    .general_output_two(general_output_two),
    .card_detect_irq(card_detect_irq)
);

// file: cdrsw_far_model.sv
`timescale 1ns/1ps
module cdrsw_far_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sense_field_on,
    input wire logic wake_cmd,
    input wire logic [9:0] gain_set,
    output logic standby_wake,
    output logic [9:0] gain_level
);
    logic [2:0] dly;
    logic [9:0] junk;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dly <= 3'h0;
            junk <= 10'h0;
        end else begin
            dly <= {dly[1:0], wake_cmd};
            junk <= ~junk;
        end
    end
    // wake counter fires a few cycles after being asked
    assign standby_wake = dly[2];
    // gain level means nothing without the field
    assign gain_level = sense_field_on ? gain_set : junk;
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cdrsw_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic [9:0] gain;
        logic hit;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] of;
    } cdrsw_case_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    cdrsw_apb_req_t req = '0;
    cdrsw_apb_rsp_t rsp;
    logic wake_cmd = 1'b0;
    logic [9:0] gain_set = 10'h0;
    logic wake, field, out1, out2, irq, err, o2_exp;
    logic [9:0] gain;
    logic [31:0] rd;
    logic [7:0] cur_cfg = 8'hff;
    int fail_count = 0;
    int n_checks = 0;
    int fld_n = 0;
    int o1_n = 0;
    int o1f_n = 0;
    int f0;
    logic [7:0] ri [8] = '{8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a,
        8'h40, 8'h43};
    logic [31:0] rm [8] = '{32'h3fff, 32'hff, 32'hff, 32'hff, 32'hff,
        32'hff, 32'h3fff, 32'h3};
    cdrsw_case_t cs [8] = '{
        '{8'h00, 10'h200, 1'b0, 8'h00, 8'h00, 8'h00},
        '{8'h04, 10'h1f0, 1'b0, 8'hca, 8'hca, 8'ha1},
        '{8'h10, 10'h1ef, 1'b1, 8'h66, 8'h66, 8'ha1},
        '{8'h0a, 10'h080, 1'b0, 8'h00, 8'h00, 8'h00},
        '{8'h0a, 10'h200, 1'b1, 8'h00, 8'h00, 8'h00},
        '{8'h0b, 10'h000, 1'b0, 8'h00, 8'h00, 8'h00},
        '{8'h09, 10'h155, 1'b0, 8'h00, 8'h00, 8'h00},
        '{8'h09, 10'h166, 1'b1, 8'h00, 8'h00, 8'h00}};
    cdrsw_core uut (.core_clk(core_clk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .standby_wake(wake), .gain_level(gain),
        .sense_field_on(field), .general_output_one(out1),
        .general_output_two(out2), .card_detect_irq(irq));
    cdrsw_far_model far (.core_clk(core_clk), .rst(rst),
        .sense_field_on(field), .wake_cmd(wake_cmd),
        .gain_set(gain_set), .standby_wake(wake), .gain_level(gain));
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        fld_n += field;
        o1_n += out1 && !field;
        o1f_n += out1 && field;
    end
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, wr, {2'h0, idx, 2'h0}, wd};
        @(posedge core_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
            end_of_test();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h42, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 900);
        if (n >= 900) begin
            fail_count++;
            end_of_test();
        end
    endtask
    task run(input cdrsw_case_t c);
        int o0, q0;
        if (c.cfg !== cur_cfg)
            apb(1'b1, 8'h38, {24'h0, c.cfg});
        cur_cfg = c.cfg;
        gain_set <= c.gain;
        f0 = fld_n;
        o0 = o1_n;
        q0 = o1f_n;
        apb(1'b1, 8'h26, 32'h0);
        poll(1);
        check("hit", rd[0], c.hit);
        check("irq", irq, 1'b1);
        o2_exp = o2_exp | (c.hit & c.cfg[3]);
        check("out2", out2, o2_exp);
        check("field", fld_n - f0, 161);
        check("lead", (o1_n - o0) >= c.lo && (o1_n - o0) <= c.hi, 1);
        check("out1", o1f_n - q0, c.of);
        apb(1'b1, 8'h42, 32'h3);
        apb(1'b0, 8'h42, 32'h0);
        check("clear", rd, 32'h0);
    endtask
    task wake_wait(input int tgt);
        int n;
        @(posedge core_clk);
        wake_cmd <= 1'b1;
        @(posedge core_clk);
        wake_cmd <= 1'b0;
        n = 0;
        while ((fld_n - f0 < tgt || out1 !== 1'b0) && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            end_of_test();
        end
        check("loop", fld_n - f0, tgt);
    endtask
    initial begin
        o2_exp = 1'b0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ri[i], 32'h0);
            check("reset", rd, 32'h0);
            apb(1'b1, ri[i], 32'hffffffff);
            apb(1'b0, ri[i], 32'h0);
            check("width", rd, rm[i]);
        end
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h39, 32'h1);
        apb(1'b1, 8'h3a, 32'h1);
        apb(1'b1, 8'h36, 32'h1);
        apb(1'b1, 8'h37, 32'h10);
        apb(1'b1, 8'h34, 32'h200);
        apb(1'b1, 8'h40, 32'h3c80);
        for (int i = 0; i < 8; i++)
            run(cs[i]);
        apb(1'b0, 8'h44, 32'h0);
        check("measured", rd, 32'h4155);
        apb(1'b1, 8'h43, 32'h0);
        apb(1'b1, 8'h26, 32'h0);
        poll(1);
        check("masked", irq, 1'b0);
        apb(1'b0, 8'h26, 32'h0);
        check("result", rd, 32'h1);
        apb(1'b1, 8'h43, 32'h1);
        apb(1'b0, 8'h42, 32'h0);
        check("unmasked", irq, 1'b1);
        apb(1'b1, 8'h42, 32'h1);
        apb(1'b0, 8'h42, 32'h0);
        check("w1c", rd, 32'h2);
        check("irq_low", irq, 1'b0);
        apb(1'b1, 8'h38, 32'h10);
        gain_set <= 10'h200;
        apb(1'b1, 8'h41, 32'h1);
        f0 = fld_n;
        wake_wait(161);
        wake_wait(322);
        gain_set <= 10'h000;
        wake_wait(483);
        poll(0);
        apb(1'b0, 8'h41, 32'h0);
        check("loop_stop", rd, 32'h0);
        end_of_test();
    end
endmodule
